// >>> rtl/bert_regs.vh
// register map, field positions and constants of the bit error-rate tester
`ifndef BERT_REGS_VH
`define BERT_REGS_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define BERT_IDX_CTRL 8'h00
`define BERT_IDX_PCFG1 8'h02
`define BERT_IDX_PCFG2 8'h03
`define BERT_IDX_SEED0 8'h04
`define BERT_IDX_SEED1 8'h05
`define BERT_IDX_SEED2 8'h06
`define BERT_IDX_SEED3 8'h07
`define BERT_IDX_STATUS 8'h0C
`define BERT_IDX_TEST 8'h10
`define BERT_IDX_PM_BITS 8'h20
`define BERT_IDX_PM_ERRS 8'h21

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BERT_CTRL_UPD_MODE 7
`define BERT_CTRL_LOCAL_UPD 6
`define BERT_CTRL_RX_LOAD 5
`define BERT_CTRL_RX_INV 4
`define BERT_CTRL_MAN_RESYNC 3
`define BERT_CTRL_AUTO_DIS 2
`define BERT_CTRL_TX_LOAD 1
`define BERT_CTRL_TX_INV 0
`define BERT_PCFG1_QUASI_RANDOM_ENABLE 6
`define BERT_PCFG1_PTS 5
`define BERT_STAT_DONE 3
`define BERT_STAT_SYNC 0
`define BERT_TEST_EN 0
`define BERT_TEST_CH_HI 7
`define BERT_TEST_CH_LO 5

// ----------------------------------------------------------------------------
// reset values, masks and pattern constants
// ----------------------------------------------------------------------------
`define BERT_RST_BYTE 8'h00
`define BERT_RST_WORD 32'h0000_0000
`define BERT_PCFG1_MASK 8'h7F
`define BERT_PCFG2_MASK 8'h1F
`define BERT_TEST_MASK 8'hE1
`define BERT_QUASI_RANDOM_ENABLE_LEN_IDX 5'h13
`define BERT_QUASI_RANDOM_ENABLE_TAP_IDX 5'h10
`define BERT_QUASI_RANDOM_ENABLE_ZTOP 19
`define BERT_QUASI_RANDOM_ENABLE_ZLOW 6
`define BERT_HUNT_LAST 6'h1F
`define BERT_WIN_LAST 6'h3F
`define BERT_ERR_LIMIT 3'h6
`define BERT_HTRANS_NONSEQ 2'h2

`endif

// >>> rtl/bert_pgen.v
// pattern generator shared by transmit and receive paths of the tester
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.vh"

module bert_pgen
(
  input wire hclk,
  input wire hresetn,
  input wire load,
  input wire step,
  input wire capture,
  input wire din,
  input wire [31:0] seed,
  input wire quasi_random_enable,
  input wire pattern_type_sel,
  input wire [4:0] length_feedback_field,
  input wire [4:0] tap_feedback_field,
  output wire bit_out,
  output wire next_bit
);

  reg [31:0] state_q;
  reg quasi_random_enable_q;
  reg pts_q;
  reg [4:0] plf_q;
  reg [4:0] ptf_q;
  wire [4:0] len_idx;
  wire [4:0] tap_idx;
  wire len_bit;
  wire fb;
  wire zero_run;

  // ----------------------------------------------------------------------------
  // feedback selection
  // ----------------------------------------------------------------------------
  // fixed 20/17 polynomial overrides the programmed fields
  assign len_idx = quasi_random_enable_q ? `BERT_QUASI_RANDOM_ENABLE_LEN_IDX : plf_q;
  assign tap_idx = quasi_random_enable_q ? `BERT_QUASI_RANDOM_ENABLE_TAP_IDX : ptf_q;
  assign len_bit = state_q[len_idx];
  // repetitive patterns recirculate bit n alone, tap ignored
  assign fb = (pts_q & ~quasi_random_enable_q) ? len_bit : (len_bit ^ state_q[tap_idx]);
  // the next 14 outputs sit in bits 19 down to 6 of the register
  assign zero_run = ~|state_q[`BERT_QUASI_RANDOM_ENABLE_ZTOP:`BERT_QUASI_RANDOM_ENABLE_ZLOW];
  assign bit_out = len_bit | (quasi_random_enable_q & zero_run);
  // bit about to enter the register is what the line carries now; no zero-run forcing here
  assign next_bit = fb;

  // ----------------------------------------------------------------------------
  // generator register
  // ----------------------------------------------------------------------------
  // load latches config so later register writes do not disturb the pattern
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= `BERT_RST_WORD;
      quasi_random_enable_q <= 1'b0;
      pts_q <= 1'b0;
      plf_q <= 5'h00;
      ptf_q <= 5'h00;
    end
    else if (load)
    begin
      state_q <= seed;
      quasi_random_enable_q <= quasi_random_enable;
      pts_q <= pattern_type_sel;
      plf_q <= length_feedback_field;
      ptf_q <= tap_feedback_field;
    end
    else if (step)
    begin
      state_q <= {state_q[30:0], capture ? din : fb};
    end
  end

endmodule // bert_pgen
`default_nettype wire

// >>> rtl/bert_core.v
// bit error-rate tester core: register slave, pattern paths, error counters
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.vh"

module bert_core
#(
  parameter NCH = 8
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire external_update_req,
  input wire [NCH-1:0] tx_bit_clock,
  input wire [NCH-1:0] rx_bit_clock,
  input wire [NCH-1:0] rx_data,
  output reg [NCH-1:0] tx_data,
  output reg [NCH-1:0] tx_data_sel,
  output reg rx_in_sync
);

  localparam RX_HUNT = 1'b0;
  localparam RX_LOCK = 1'b1;

  // software registers
  reg [7:0] ctrl_q;
  reg [7:0] pcfg1_q;
  reg [7:0] pcfg2_q;
  reg [31:0] seed_q;
  reg [7:0] test_q;
  reg [31:0] pm_bits_q;
  reg [31:0] pm_errs_q;
  reg done_q;
  // bus slave state
  reg wr_pend_q;
  reg rd_pend_q;
  reg [7:0] idx_q;
  // synchronisers
  reg [NCH-1:0] txc_s1_q;
  reg [NCH-1:0] txc_s2_q;
  reg [NCH-1:0] txc_s3_q;
  reg [NCH-1:0] rxc_s1_q;
  reg [NCH-1:0] rxc_s2_q;
  reg [NCH-1:0] rxc_s3_q;
  reg [NCH-1:0] rxd_s1_q;
  reg [NCH-1:0] rxd_s2_q;
  reg ext_s1_q;
  reg ext_s2_q;
  // edge capture and pending actions
  reg [7:0] ctrl_prev_q;
  reg tx_load_pend_q;
  reg rx_load_pend_q;
  reg resync_pend_q;
  reg trig_prev_q;
  reg upd_q;
  // receive checker
  reg rx_state_q;
  reg [5:0] hunt_cnt_q;
  reg [5:0] win_cnt_q;
  reg [2:0] win_errs_q;
  reg [31:0] bit_cnt_q;
  reg [31:0] err_cnt_q;

  wire [2:0] chan;
  wire tester_enable;
  wire tx_tick;
  wire rx_tick;
  wire rx_bit;
  wire tx_gen_bit;
  wire rx_pred;
  wire mismatch;
  wire trig;
  wire trig_rise;
  wire [7:0] ctrl_rise;
  wire addr_ok;
  wire rx_restart;
  wire win_overflow;

  // ----------------------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------------------
  // read mux, shared by the slave data phase
  function [31:0] read_word;
    input [7:0] idx;
    begin
      if (idx == `BERT_IDX_CTRL)
        read_word = {24'h00_0000, ctrl_q};
      else if (idx == `BERT_IDX_PCFG1)
        read_word = {24'h00_0000, pcfg1_q};
      else if (idx == `BERT_IDX_PCFG2)
        read_word = {24'h00_0000, pcfg2_q};
      else if (idx == `BERT_IDX_SEED0)
        read_word = {24'h00_0000, seed_q[7:0]};
      else if (idx == `BERT_IDX_SEED1)
        read_word = {24'h00_0000, seed_q[15:8]};
      else if (idx == `BERT_IDX_SEED2)
        read_word = {24'h00_0000, seed_q[23:16]};
      else if (idx == `BERT_IDX_SEED3)
        read_word = {24'h00_0000, seed_q[31:24]};
      else if (idx == `BERT_IDX_STATUS)
        read_word = {28'h000_0000, done_q, 2'b00, rx_in_sync};
      else if (idx == `BERT_IDX_TEST)
        read_word = {24'h00_0000, test_q};
      else if (idx == `BERT_IDX_PM_BITS)
        read_word = pm_bits_q;
      else if (idx == `BERT_IDX_PM_ERRS)
        read_word = pm_errs_q;
      else
        read_word = `BERT_RST_WORD;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------------------
  // only word-aligned addresses below 0x400 map; others read zero and ignore writes
  assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h00_0000);

  // writes finish with no wait; reads add one wait so a write just before is seen
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= `BERT_RST_BYTE;
      hrdata <= `BERT_RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      if (rd_pend_q)
      begin
        hrdata <= read_word(idx_q);
        hreadyout <= 1'b1;
        rd_pend_q <= 1'b0;
      end
      else if (hready && hsel && htrans[1])
      begin
        idx_q <= addr_ok ? haddr[9:2] : 8'hFF;
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  // register writes in the data phase; unused bits stay zero
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `BERT_RST_BYTE;
      pcfg1_q <= `BERT_RST_BYTE;
      pcfg2_q <= `BERT_RST_BYTE;
      seed_q <= `BERT_RST_WORD;
      test_q <= `BERT_RST_BYTE;
    end
    else if (wr_pend_q)
    begin
      if (idx_q == `BERT_IDX_CTRL)
        ctrl_q <= hwdata[7:0];
      else if (idx_q == `BERT_IDX_PCFG1)
        pcfg1_q <= hwdata[7:0] & `BERT_PCFG1_MASK;
      else if (idx_q == `BERT_IDX_PCFG2)
        pcfg2_q <= hwdata[7:0] & `BERT_PCFG2_MASK;
      else if (idx_q == `BERT_IDX_SEED0)
        seed_q[7:0] <= hwdata[7:0];
      else if (idx_q == `BERT_IDX_SEED1)
        seed_q[15:8] <= hwdata[7:0];
      else if (idx_q == `BERT_IDX_SEED2)
        seed_q[23:16] <= hwdata[7:0];
      else if (idx_q == `BERT_IDX_SEED3)
        seed_q[31:24] <= hwdata[7:0];
      else if (idx_q == `BERT_IDX_TEST)
        test_q <= hwdata[7:0] & `BERT_TEST_MASK;
    end
  end

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  // third stage of each clock feeds the edge finder, never the first
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      txc_s1_q <= {NCH{1'b0}};
      txc_s2_q <= {NCH{1'b0}};
      txc_s3_q <= {NCH{1'b0}};
      rxc_s1_q <= {NCH{1'b0}};
      rxc_s2_q <= {NCH{1'b0}};
      rxc_s3_q <= {NCH{1'b0}};
      rxd_s1_q <= {NCH{1'b0}};
      rxd_s2_q <= {NCH{1'b0}};
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end
    else
    begin
      txc_s1_q <= tx_bit_clock;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
      rxc_s1_q <= rx_bit_clock;
      rxc_s2_q <= rxc_s1_q;
      rxc_s3_q <= rxc_s2_q;
      rxd_s1_q <= rx_data;
      rxd_s2_q <= rxd_s1_q;
      ext_s1_q <= external_update_req;
      ext_s2_q <= ext_s1_q;
    end
  end

  // ----------------------------------------------------------------------------
  // channel selection and bit clock ticks
  // ----------------------------------------------------------------------------
  assign tester_enable = test_q[`BERT_TEST_EN];
  assign chan = test_q[`BERT_TEST_CH_HI:`BERT_TEST_CH_LO];
  // nothing advances while the tester is off
  assign tx_tick = tester_enable & txc_s2_q[chan] & ~txc_s3_q[chan];
  assign rx_tick = tester_enable & rxc_s2_q[chan] & ~rxc_s3_q[chan];
  // data sampled with the same delay as the clock, so it is centred on the edge
  assign rx_bit = rxd_s2_q[chan] ^ ctrl_q[`BERT_CTRL_RX_INV];

  // ----------------------------------------------------------------------------
  // control edges held until the owning bit clock arrives
  // ----------------------------------------------------------------------------
  assign ctrl_rise = ctrl_q & ~ctrl_prev_q;

  // a new edge in the tick cycle wins over the clear, so none is lost
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_prev_q <= `BERT_RST_BYTE;
      tx_load_pend_q <= 1'b0;
      rx_load_pend_q <= 1'b0;
      resync_pend_q <= 1'b0;
    end
    else
    begin
      ctrl_prev_q <= ctrl_q;
      if (ctrl_rise[`BERT_CTRL_TX_LOAD])
        tx_load_pend_q <= 1'b1;
      else if (tx_tick)
        tx_load_pend_q <= 1'b0;
      if (ctrl_rise[`BERT_CTRL_RX_LOAD])
        rx_load_pend_q <= 1'b1;
      else if (rx_tick)
        rx_load_pend_q <= 1'b0;
      if (ctrl_rise[`BERT_CTRL_MAN_RESYNC])
        resync_pend_q <= 1'b1;
      else if (rx_tick)
        resync_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------------------
  bert_pgen u_tx_gen
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(tx_tick & tx_load_pend_q),
    .step(tx_tick & ~tx_load_pend_q),
    .capture(1'b0),
    .din(1'b0),
    .seed(seed_q),
    .quasi_random_enable(pcfg1_q[`BERT_PCFG1_QUASI_RANDOM_ENABLE]),
    .pattern_type_sel(pcfg1_q[`BERT_PCFG1_PTS]),
    .length_feedback_field(pcfg1_q[4:0]),
    .tap_feedback_field(pcfg2_q[4:0]),
    .bit_out(tx_gen_bit),
    .next_bit()
  );

  // outgoing bit changes one system clock after the tick; only the chosen lane carries it
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_data <= {NCH{1'b0}};
      tx_data_sel <= {NCH{1'b0}};
    end
    else
    begin
      tx_data_sel <= tester_enable ? ({{(NCH-1){1'b0}}, 1'b1} << chan) : {NCH{1'b0}};
      if (tx_tick)
        tx_data <= {NCH{tx_gen_bit ^ ctrl_q[`BERT_CTRL_TX_INV]}} & tx_data_sel;
      else if (!tester_enable)
        tx_data <= {NCH{1'b0}};
    end
  end

  // ----------------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------------
  // while hunting the generator fills itself from the line
  bert_pgen u_rx_gen
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(rx_tick & rx_load_pend_q),
    .step(rx_tick & ~rx_load_pend_q),
    .capture(rx_state_q == RX_HUNT),
    .din(rx_bit),
    .seed(seed_q),
    .quasi_random_enable(pcfg1_q[`BERT_PCFG1_QUASI_RANDOM_ENABLE]),
    .pattern_type_sel(pcfg1_q[`BERT_PCFG1_PTS]),
    .length_feedback_field(pcfg1_q[4:0]),
    .tap_feedback_field(pcfg2_q[4:0]),
    .bit_out(),
    .next_bit(rx_pred)
  );

  // the delayed output bit lags the line by n bits, so compare with the prediction
  assign mismatch = rx_bit ^ rx_pred;
  assign rx_restart = rx_load_pend_q | resync_pend_q;
  // the current bit counts toward the window total
  assign win_overflow = (win_errs_q + {2'b00, mismatch}) >= `BERT_ERR_LIMIT;

  // sync state machine; 32 captured bits fill the register, then lock
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_q <= RX_HUNT;
      hunt_cnt_q <= 6'h00;
      win_cnt_q <= 6'h00;
      win_errs_q <= 3'h0;
      rx_in_sync <= 1'b0;
    end
    else if (rx_tick)
    begin
      if (rx_restart)
      begin
        rx_state_q <= RX_HUNT;
        hunt_cnt_q <= 6'h00;
        rx_in_sync <= 1'b0;
      end
      else
      begin
        case (rx_state_q)
          RX_HUNT:
          begin
            hunt_cnt_q <= hunt_cnt_q + 6'h01;
            if (hunt_cnt_q == `BERT_HUNT_LAST)
            begin
              rx_state_q <= RX_LOCK;
              rx_in_sync <= 1'b1;
              win_cnt_q <= 6'h00;
              win_errs_q <= 3'h0;
            end
          end
          default:
          begin
            win_cnt_q <= win_cnt_q + 6'h01;
            if (win_overflow && !ctrl_q[`BERT_CTRL_AUTO_DIS])
            begin
              rx_state_q <= RX_HUNT;
              hunt_cnt_q <= 6'h00;
              rx_in_sync <= 1'b0;
            end
            else if (win_cnt_q == `BERT_WIN_LAST)
              win_errs_q <= 3'h0;
            else if (mismatch && !win_overflow)
              win_errs_q <= win_errs_q + 3'h1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // performance monitoring update
  // ----------------------------------------------------------------------------
  // mode change with a high source also yields an edge here
  assign trig = ctrl_q[`BERT_CTRL_UPD_MODE] ? ext_s2_q : ctrl_q[`BERT_CTRL_LOCAL_UPD];
  assign trig_rise = trig & ~trig_prev_q;

  // counters restart at 0, or 1 if a bit (for the error count, an errored bit) lands in the snapshot cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_prev_q <= 1'b0;
      upd_q <= 1'b0;
      done_q <= 1'b0;
      bit_cnt_q <= `BERT_RST_WORD;
      err_cnt_q <= `BERT_RST_WORD;
      pm_bits_q <= `BERT_RST_WORD;
      pm_errs_q <= `BERT_RST_WORD;
    end
    else
    begin
      trig_prev_q <= trig;
      upd_q <= trig_rise;
      if (trig_rise)
      begin
        pm_bits_q <= bit_cnt_q;
        pm_errs_q <= err_cnt_q;
        bit_cnt_q <= {31'h0000_0000, rx_tick & rx_in_sync};
        err_cnt_q <= {31'h0000_0000, rx_tick & rx_in_sync & mismatch};
      end
      else if (rx_tick && rx_in_sync)
      begin
        bit_cnt_q <= bit_cnt_q + 32'h0000_0001;
        err_cnt_q <= err_cnt_q + {31'h0000_0000, mismatch};
      end
      // completion sets the flag; a low trigger drops it
      if (upd_q)
        done_q <= 1'b1;
      else if (!trig)
        done_q <= 1'b0;
    end
  end

endmodule // bert_core
`default_nettype wire

// >>> test/bert_core_props.sv
// concurrent checks on the tester core ports
`timescale 1ns/100ps
`default_nettype none
module bert_core_props #(parameter NCH = 8)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NCH-1:0] rx_bit_clock,
  input wire logic [NCH-1:0] tx_data,
  input wire logic [NCH-1:0] tx_data_sel,
  input wire logic rx_in_sync
);
  // ------------------------------------------------------------
  // helper logic and properties
  // ------------------------------------------------------------
  logic [NCH-1:0] rx_prev_q;
  logic [2:0] rx_age_q;

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // age of the last receive bit clock rise, held at 7 so it never wraps
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rx_prev_q <= '0;
      rx_age_q <= 3'h7;
    end
    else
    begin
      rx_prev_q <= rx_bit_clock;
      rx_age_q <= (|(rx_bit_clock & ~rx_prev_q)) ? 3'h0 : rx_age_q + {2'h0, rx_age_q != 3'h7};
    end

  // bus request kinds and the single read wait state
  sequence rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_req;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (rd_req |=> one_wait)
    else $error("read did not take one wait state");
  a_write_nowait: assert property (wr_req |=> hreadyout)
    else $error("write stalled the bus");
  a_sel_onehot: assert property ($onehot0(tx_data_sel))
    else $error("more than one channel selected");
  a_tx_in_sel: assert property ((tx_data & ~tx_data_sel) == '0)
    else $error("pattern on an unselected channel");
  a_reset_quiet: assert property ($rose(hresetn) |->
    tx_data == '0 && tx_data_sel == '0 && !rx_in_sync && hreadyout)
    else $error("outputs not quiet after reset");
  a_sync_on_tick: assert property ($rose(rx_in_sync) |-> rx_age_q <= 3'h6)
    else $error("lock not tied to a receive bit");
  a_drop_on_tick: assert property ($fell(rx_in_sync) |-> rx_age_q <= 3'h6)
    else $error("loss of lock not tied to a receive bit");
endmodule // bert_core_props

bind bert_core bert_core_props #(.NCH(NCH)) u_props
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .rx_bit_clock(rx_bit_clock),
  .tx_data(tx_data), .tx_data_sel(tx_data_sel), .rx_in_sync(rx_in_sync)
);
`default_nettype wire

// >>> test/bert_far.sv
// far end model: bit clocks for the selected channel and a data loop
`timescale 1ns/100ps
`default_nettype none
module bert_far #(parameter NCH = 8)
(
  input wire logic run,
  input wire logic [2:0] ch,
  input wire logic flip,
  input wire logic [NCH-1:0] tx_data,
  output logic [NCH-1:0] tx_bit_clock,
  output logic [NCH-1:0] rx_bit_clock,
  output logic [NCH-1:0] rx_data,
  output logic lclk
);
  // ------------------------------------------------------------
  // line clock and loop
  // ------------------------------------------------------------
  logic [NCH-1:0] one;

  // 80 ns line clock, held low while the line is stopped
  initial
  begin
    lclk = 1'b0;
    forever
    begin
      #40;
      lclk = run & ~lclk;
    end
  end

  // receive clock is the inverse, so bits are sampled mid-period
  assign one = {{(NCH-1){1'b0}}, 1'b1} << ch;
  assign tx_bit_clock = lclk ? one : '0;
  assign rx_bit_clock = (run & ~lclk) ? one : '0;
  // looped data, optionally inverted; idle channels follow the line clock, toggling every half bit
  assign rx_data = ((tx_data[ch] ^ flip) ? one : '0) | ({NCH{lclk}} & ~one);
endmodule // bert_far
`default_nettype wire

// >>> test/bert_core_bench.sv
// self-checking bench for the tester core with a looped far end
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.vh"
module bert_core_bench;
  logic hclk, hresetn, hsel, hwrite, rdy, hresp, ext, run, flip, sync, lclk;
  logic [1:0] htrans;
  logic [2:0] hsize, ch;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] txc, rxc, rxd, txd, tsel;
  int mismatches, n_checks;

  bert_core #(.NCH(8)) uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
    .hreadyout(rdy), .hresp(hresp), .external_update_req(ext), .tx_bit_clock(txc),
    .rx_bit_clock(rxc), .rx_data(rxd), .tx_data(txd), .tx_data_sel(tsel), .rx_in_sync(sync)
  );
  bert_far #(.NCH(8)) far
  (
    .run(run), .ch(ch), .flip(flip), .tx_data(txd), .tx_bit_clock(txc),
    .rx_bit_clock(rxc), .rx_data(rxd), .lclk(lclk)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    mismatches++;
    test_done();
  endtask

  // ready is read before this edge's updates land, i.e. as sampled
  task automatic waitrdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (rdy !== 1'b1)
    begin
      i++;
      if (i == 50) hang();
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `BERT_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitrdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge lclk);
  endtask

  task automatic waitfor(input logic want);
    int i;
    for (i = 0; sync !== want; i++)
    begin
      if (i == 6000) hang();
      @(posedge hclk);
    end
  endtask

  task automatic waitdone;
    int i;
    for (i = 0; i < 200; i++)
    begin
      bus(1'b0, `BERT_IDX_STATUS, 8'h00);
      if (rd[`BERT_STAT_DONE] === 1'b1) return;
    end
    hang();
  endtask

  // 16 mid-bit samples must be a rotation of p, sent msb first
  task automatic txpat(input logic [7:0] p);
    logic [15:0] b;
    int i, ok;
    ticks(4);
    for (i = 0; i < 16; i++)
    begin
      @(negedge lclk);
      b[15-i] = txd[ch];
    end
    ok = 0;
    for (i = 0; i < 8; i++)
      if (b === {2{(p << i) | (p >> (8 - i))}}) ok = 1;
    chk(ok, 1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset values, reserved bits, a hole in the map, idle outputs
  task automatic regs_test;
    rdchk(`BERT_IDX_CTRL, 32'h0000_0000);
    wr(`BERT_IDX_PCFG1, 8'hFF);
    rdchk(`BERT_IDX_PCFG1, 32'h0000_007F);
    wr(`BERT_IDX_PCFG2, 8'hFF);
    rdchk(`BERT_IDX_PCFG2, 32'h0000_001F);
    wr(8'h01, 8'h55);
    rdchk(8'h01, 32'h0000_0000);
    chk(tsel, 8'h00);
  endtask

  // eight-bit repetitive pattern with a stray tap, then inverted
  task automatic tx_test;
    wr(`BERT_IDX_TEST, 8'h61);
    wr(`BERT_IDX_PCFG1, 8'h27);
    wr(`BERT_IDX_PCFG2, 8'h05);
    wr(`BERT_IDX_SEED0, 8'h1D);
    wr(`BERT_IDX_SEED1, 8'h96);
    wr(`BERT_IDX_CTRL, 8'h02);
    ticks(4);
    chk(tsel, 8'h08);
    txpat(8'h1D);
    wr(`BERT_IDX_CTRL, 8'h03);
    txpat(8'hE2);
    wr(`BERT_IDX_PCFG1, 8'h67);
    wr(`BERT_IDX_SEED0, 8'h00);
    wr(`BERT_IDX_SEED1, 8'h00);
    wr(`BERT_IDX_CTRL, 8'h00);
    wr(`BERT_IDX_CTRL, 8'h02);
    txpat(8'hFF);
    wr(`BERT_IDX_SEED0, 8'h1D);
    wr(`BERT_IDX_SEED1, 8'h96);
  endtask

  // prbs loop: lock, forced resync, inversion, error window, update
  task automatic rx_test;
    wr(`BERT_IDX_CTRL, 8'h00);
    wr(`BERT_IDX_PCFG1, 8'h0E);
    wr(`BERT_IDX_PCFG2, 8'h0D);
    wr(`BERT_IDX_CTRL, 8'h22);
    ticks(4);
    waitfor(1'b1);
    wr(`BERT_IDX_CTRL, 8'h2A);
    waitfor(1'b0);
    waitfor(1'b1);
    ticks(100);
    chk(sync, 1'b1);
    @(posedge hclk);
    flip <= 1'b1;
    waitfor(1'b0);
    wr(`BERT_IDX_CTRL, 8'h32);
    wr(`BERT_IDX_CTRL, 8'h3A);
    waitfor(1'b1);
    ticks(100);
    chk(sync, 1'b1);
    wr(`BERT_IDX_CTRL, 8'h3E);
    flip <= 1'b0;
    ticks(150);
    chk(sync, 1'b1);
    wr(`BERT_IDX_CTRL, 8'h7E);
    waitdone();
    bus(1'b0, `BERT_IDX_PM_ERRS, 8'h00);
    chk(rd != 0, 1'b1);
    wr(`BERT_IDX_CTRL, 8'h3E);
    rdchk(`BERT_IDX_STATUS, 32'h0000_0001);
  endtask

  // external trigger takes over and the local bit is ignored
  task automatic ext_test;
    wr(`BERT_IDX_CTRL, 8'hBE);
    wr(`BERT_IDX_CTRL, 8'hFE);
    ticks(2);
    rdchk(`BERT_IDX_STATUS, 32'h0000_0001);
    ext <= 1'b1;
    waitdone();
    ext <= 1'b0;
    ticks(1);
    rdchk(`BERT_IDX_STATUS, 32'h0000_0001);
  endtask

  // 250 MHz system clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // reset, then the scenarios in order
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    ext = 1'b0;
    run = 1'b1;
    flip = 1'b0;
    ch = 3'h3;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    regs_test();
    tx_test();
    rx_test();
    ext_test();
    test_done();
  end
endmodule // bert_core_bench
`default_nettype wire
